// file: design/silc_map.svh
// register offsets, field positions, reset values and timing counts of the serial line block
`ifndef SILC_MAP_SVH
`define SILC_MAP_SVH
// ==========================================================
// register byte offsets
`define SILC_OFS_CTRL 12'h000
`define SILC_OFS_STAT 12'h004
`define SILC_OFS_TXH 12'h008
`define SILC_OFS_RXH 12'h00C
`define SILC_OFS_BAUD 12'h010
// ==========================================================
// serial_control fields
`define SILC_C_TX_ON 0
`define SILC_C_RX_ON 1
`define SILC_C_RX_IE 2
`define SILC_C_TXE_IE 3
`define SILC_C_TXD_IE 4
`define SILC_C_PAR_EN 5
`define SILC_C_PAR_ODD 6
`define SILC_C_SYNC 7
`define SILC_C_PIN_DIR 8
`define SILC_C_PIN_LVL 9
`define SILC_CTRL_W 10
`define SILC_CTRL_RST 10'h000
// ==========================================================
// serial_status fields
`define SILC_S_RX_FULL 0
`define SILC_S_TX_EMPTY 1
`define SILC_S_TX_DONE 2
`define SILC_S_OVERRUN 3
`define SILC_S_FRAMING 4
`define SILC_S_PARITY 5
`define SILC_S_RX_PIN 6
// ==========================================================
// reset values and timing
`define SILC_BAUD_RST 16'h0019
`define SILC_TXH_RST 8'h00
`define SILC_RXH_RST 8'h00
`define SILC_OVERSAMPLE 16
`define SILC_TICKS_LAST 4'hF
`define SILC_SAMPLE_TICK 4'h7
`endif

// file: design/silc_pkg.sv
// types and shared helpers of the serial line block
package silc_pkg;
  // ==========================================================
  // frame state shared by transmitter and receiver
  typedef enum logic [2:0] {
    SILC_IDLE,
    SILC_START,
    SILC_DATA,
    SILC_PAR,
    SILC_STOP
  } silc_state_t;

  // parity bit for a byte, odd or even
  function automatic logic silc_parity(input logic [7:0] d, input logic odd);
    silc_parity = (^d) ^ odd;
  endfunction
endpackage

// file: design/silc_rx.sv
// receiver with start-edge realignment and mid-bit sampling on the basic clock
`include "silc_map.svh"
module silc_rx (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic rx_on,
  input wire logic rxd_sync,
  input wire logic par_en,
  input wire logic par_odd,
  output logic done,
  output logic [7:0] data,
  output logic frame_err,
  output logic par_err
);
  silc_pkg::silc_state_t st_r;
  logic [3:0] tcnt_r;
  logic [2:0] bit_r;
  logic prev_r;
  logic rearm_r;
  logic [7:0] sh_r;
  logic perr_r;
  wire mid = tick && (tcnt_r == `SILC_SAMPLE_TICK);
  wire bit_end = tick && (tcnt_r == `SILC_TICKS_LAST);
  // a held-low line after a bad stop bit counts as a fresh start
  wire start_seen = tick && !rxd_sync && (prev_r || rearm_r);

  // ==========================================================
  // frame sequencer; disabling only stops it, flags live elsewhere
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= silc_pkg::SILC_IDLE;
      tcnt_r <= 4'h0;
      bit_r <= 3'h0;
      prev_r <= 1'b1;
      rearm_r <= 1'b0;
      sh_r <= 8'h00;
      perr_r <= 1'b0;
      done <= 1'b0;
      data <= 8'h00;
      frame_err <= 1'b0;
      par_err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        prev_r <= rxd_sync;
      end
      if (!rx_on) begin
        st_r <= silc_pkg::SILC_IDLE;
        rearm_r <= 1'b0;
      end else begin
        case (st_r)
          silc_pkg::SILC_IDLE: begin
            if (start_seen) begin
              st_r <= silc_pkg::SILC_START;
              tcnt_r <= 4'h1;
              rearm_r <= 1'b0;
            end
          end
          silc_pkg::SILC_START: begin
            if (tick) begin
              tcnt_r <= tcnt_r + 4'h1;
            end
            if (mid && rxd_sync) begin
              st_r <= silc_pkg::SILC_IDLE; // glitch, not a start bit
            end else if (bit_end) begin
              st_r <= silc_pkg::SILC_DATA;
              bit_r <= 3'h0;
              perr_r <= 1'b0;
            end
          end
          silc_pkg::SILC_DATA: begin
            if (tick) begin
              tcnt_r <= tcnt_r + 4'h1;
            end
            if (mid) begin
              sh_r <= {rxd_sync, sh_r[7:1]};
            end
            if (bit_end) begin
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                st_r <= par_en ? silc_pkg::SILC_PAR : silc_pkg::SILC_STOP;
              end
            end
          end
          silc_pkg::SILC_PAR: begin
            if (tick) begin
              tcnt_r <= tcnt_r + 4'h1;
            end
            if (mid) begin
              perr_r <= rxd_sync != silc_pkg::silc_parity(sh_r, par_odd);
            end
            if (bit_end) begin
              st_r <= silc_pkg::SILC_STOP;
            end
          end
          silc_pkg::SILC_STOP: begin
            if (tick) begin
              tcnt_r <= tcnt_r + 4'h1;
            end
            // finish at mid stop bit so the next start edge is never missed
            if (mid) begin
              st_r <= silc_pkg::SILC_IDLE;
              done <= 1'b1;
              data <= sh_r;
              frame_err <= !rxd_sync;
              par_err <= perr_r;
              rearm_r <= !rxd_sync;
            end
          end
          default: begin
            st_r <= silc_pkg::SILC_IDLE;
          end
        endcase
      end
    end
  end
endmodule // silc_rx

// file: design/silc_top.sv
// serial line control: APB registers, flags, requests, transmitter and pin handover
//
// Decided for this implementation: register access over APB and the placing of the registers.
`include "silc_map.svh"
module silc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe,
  output logic rx_full_request,
  output logic tx_empty_request,
  output logic tx_done_request,
  output logic rx_fault_request
);
  // ==========================================================
  // registers
  logic [`SILC_CTRL_W-1:0] ctrl_r;
  logic [15:0] baud_r;
  logic [7:0] tx_holding_r;
  logic [7:0] rx_holding_r;
  logic rx_full_flag_r;
  logic tx_empty_flag_r;
  logic tx_done_flag_r;
  logic overrun_flag_r;
  logic framing_flag_r;
  logic parity_flag_r;
  logic rxd_meta_r;
  logic rxd_sync_r;
  logic [15:0] bcnt_r;
  silc_pkg::silc_state_t tst_r;
  logic [3:0] ttck_r;
  logic [2:0] tbit_r;
  logic [7:0] tsh_r;
  logic tline_r;
  logic [31:0] rdata_nxt;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_ferr;
  logic rx_perr;

  // ==========================================================
  // APB decode; slave always ready, unmapped addresses flag an error
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_ctrl = paddr == `SILC_OFS_CTRL;
  wire hit_stat = paddr == `SILC_OFS_STAT;
  wire hit_txh = paddr == `SILC_OFS_TXH;
  wire hit_rxh = paddr == `SILC_OFS_RXH;
  wire hit_baud = paddr == `SILC_OFS_BAUD;
  wire mapped = hit_ctrl || hit_stat || hit_txh || hit_rxh || hit_baud;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_stat = wr && hit_stat;
  wire wr_txh = wr && hit_txh;
  wire wr_baud = wr && hit_baud;
  wire rd_rxh = rd && hit_rxh;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ==========================================================
  // control fields
  wire tx_on = ctrl_r[`SILC_C_TX_ON];
  wire rx_on = ctrl_r[`SILC_C_RX_ON];
  wire rx_irq_en = ctrl_r[`SILC_C_RX_IE];
  wire tx_empty_irq_en = ctrl_r[`SILC_C_TXE_IE];
  wire tx_done_irq_en = ctrl_r[`SILC_C_TXD_IE];
  wire par_en = ctrl_r[`SILC_C_PAR_EN];
  wire par_odd = ctrl_r[`SILC_C_PAR_ODD];
  wire sync_mode = ctrl_r[`SILC_C_SYNC];
  wire pin_direction_ctl = ctrl_r[`SILC_C_PIN_DIR];
  wire pin_output_level = ctrl_r[`SILC_C_PIN_LVL];
  wire any_err = overrun_flag_r || framing_flag_r || parity_flag_r;

  // ==========================================================
  // status word and read mux
  wire [6:0] serial_status = {rxd_sync_r, parity_flag_r, framing_flag_r,
    overrun_flag_r, tx_done_flag_r, tx_empty_flag_r, rx_full_flag_r};
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_nxt = {22'h000000, ctrl_r};
    end else if (hit_stat) begin
      rdata_nxt = {25'h0000000, serial_status};
    end else if (hit_txh) begin
      rdata_nxt = {24'h000000, tx_holding_r};
    end else if (hit_rxh) begin
      rdata_nxt = {24'h000000, rx_holding_r};
    end else if (hit_baud) begin
      rdata_nxt = {16'h0000, baud_r};
    end
  end
  // read data from a flop, loaded in the setup cycle so it is valid in access
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= `SILC_CTRL_RST;
      baud_r <= `SILC_BAUD_RST;
      tx_holding_r <= `SILC_TXH_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[`SILC_CTRL_W-1:0];
      end
      if (wr_baud) begin
        baud_r <= pwdata[15:0];
      end
      if (wr_txh) begin
        tx_holding_r <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // receive pin synchroniser, two flops before any use
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rxd_meta_r <= 1'b1;
      rxd_sync_r <= 1'b1;
    end else begin
      rxd_meta_r <= rxd_i;
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // ==========================================================
  // basic clock: one tick per divisor+1 cycles, sixteen ticks per bit
  // compare with >= so a smaller divisor written mid-count never waits for a counter wrap
  wire tick = bcnt_r >= baud_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bcnt_r <= 16'h0000;
    end else begin
      bcnt_r <= tick ? 16'h0000 : bcnt_r + 16'h0001;
    end
  end

  silc_rx u_rx (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tick(tick),
    .rx_on(rx_on),
    .rxd_sync(rxd_sync_r),
    .par_en(par_en),
    .par_odd(par_odd),
    .done(rx_done),
    .data(rx_data),
    .frame_err(rx_ferr),
    .par_err(rx_perr)
  );

  // ==========================================================
  // receive side flags; hardware set wins over software clear
  wire overrun = rx_done && rx_full_flag_r;
  wire rx_take = rx_done && !rx_full_flag_r;
  wire clr_rxf = (wr_stat && !pwdata[`SILC_S_RX_FULL]) || rd_rxh;
  wire clr_ovr = wr_stat && !pwdata[`SILC_S_OVERRUN];
  wire clr_frm = wr_stat && !pwdata[`SILC_S_FRAMING];
  wire clr_par = wr_stat && !pwdata[`SILC_S_PARITY];
  // rx_on is deliberately absent here: turning the receiver off keeps the flags
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_holding_r <= `SILC_RXH_RST;
      rx_full_flag_r <= 1'b0;
      overrun_flag_r <= 1'b0;
      framing_flag_r <= 1'b0;
      parity_flag_r <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_holding_r <= rx_data;
      end
      rx_full_flag_r <= rx_take || overrun || (rx_full_flag_r && !clr_rxf);
      overrun_flag_r <= overrun || (overrun_flag_r && !clr_ovr);
      framing_flag_r <= (rx_take && rx_ferr) || (framing_flag_r && !clr_frm);
      parity_flag_r <= (rx_take && rx_perr) || (parity_flag_r && !clr_par);
    end
  end

  // ==========================================================
  // transmitter start and flags
  wire tx_idle = tst_r == silc_pkg::SILC_IDLE;
  wire tx_load = tx_on && tx_idle && !tx_empty_flag_r && !(sync_mode && any_err);
  wire tx_frame_end = tst_r == silc_pkg::SILC_STOP && tick && ttck_r == `SILC_TICKS_LAST;
  wire set_done = tx_frame_end && tx_empty_flag_r;
  wire clr_done = (wr_stat && !pwdata[`SILC_S_TX_DONE]) || wr_txh || tx_load;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_empty_flag_r <= 1'b1;
      tx_done_flag_r <= 1'b1;
    end else begin
      tx_empty_flag_r <= tx_load || (tx_empty_flag_r && !wr_txh);
      tx_done_flag_r <= set_done || (tx_done_flag_r && !clr_done);
    end
  end

  // ==========================================================
  // transmit frame; tx_on low throws the frame away at once
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tst_r <= silc_pkg::SILC_IDLE;
      ttck_r <= 4'h0;
      tbit_r <= 3'h0;
      tsh_r <= 8'h00;
      tline_r <= 1'b1;
    end else if (!tx_on) begin
      tst_r <= silc_pkg::SILC_IDLE;
      ttck_r <= 4'h0;
      tline_r <= 1'b1;
    end else begin
      if (tick && !tx_idle) begin
        ttck_r <= ttck_r + 4'h1;
      end
      case (tst_r)
        silc_pkg::SILC_IDLE: begin
          tline_r <= 1'b1;
          if (tx_load) begin
            tsh_r <= tx_holding_r;
            tst_r <= silc_pkg::SILC_START;
            ttck_r <= 4'h0;
          end
        end
        silc_pkg::SILC_START: begin
          tline_r <= 1'b0;
          if (tick && ttck_r == `SILC_TICKS_LAST) begin
            tst_r <= silc_pkg::SILC_DATA;
            tbit_r <= 3'h0;
          end
        end
        silc_pkg::SILC_DATA: begin
          tline_r <= tsh_r[tbit_r];
          if (tick && ttck_r == `SILC_TICKS_LAST) begin
            tbit_r <= tbit_r + 3'h1;
            if (tbit_r == 3'h7) begin
              tst_r <= par_en ? silc_pkg::SILC_PAR : silc_pkg::SILC_STOP;
            end
          end
        end
        silc_pkg::SILC_PAR: begin
          tline_r <= silc_pkg::silc_parity(tsh_r, par_odd);
          if (tick && ttck_r == `SILC_TICKS_LAST) begin
            tst_r <= silc_pkg::SILC_STOP;
          end
        end
        silc_pkg::SILC_STOP: begin
          tline_r <= 1'b1;
          if (tx_frame_end) begin
            tst_r <= silc_pkg::SILC_IDLE;
          end
        end
        default: begin
          tst_r <= silc_pkg::SILC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin ownership: serial line when enabled, else port bits
  assign txd_o = tx_on ? tline_r : pin_output_level;
  assign txd_oe = tx_on ? 1'b1 : pin_direction_ctl;

  // ==========================================================
  // level requests from flag and enable
  assign rx_full_request = rx_full_flag_r && rx_irq_en;
  assign tx_empty_request = tx_empty_flag_r && tx_empty_irq_en;
  assign tx_done_request = tx_done_flag_r && tx_done_irq_en;
  assign rx_fault_request = any_err && rx_irq_en;
endmodule // silc_top

// file: tb/silc_chk_assertions.sv
// port checker of the serial line block and its bind
`include "silc_map.svh"
module silc_chk (
  input logic sys_clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic rxd_i,
  input logic txd_o,
  input logic txd_oe,
  input logic rx_full_request,
  input logic tx_empty_request,
  input logic tx_done_request,
  input logic rx_fault_request
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // shadow state
  logic [9:0] ctrl_r;
  logic touched_r;
  wire wr_acc = psel && penable && pwrite;
  wire wr_ctl = wr_acc && paddr == `SILC_OFS_CTRL;
  wire wr_txh = wr_acc && paddr == `SILC_OFS_TXH;
  wire wr_st = wr_acc && paddr == `SILC_OFS_STAT;
  // control copy; touched marks anything that could clear the empty or done flag
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 10'h000;
      touched_r <= 1'b0;
    end else begin
      if (wr_ctl) ctrl_r <= pwdata[9:0];
      if (wr_txh || (wr_st && !pwdata[2])) touched_r <= 1'b1;
    end
  end
  // ====================
  // assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_port_pin: assert property (!ctrl_r[0] |-> txd_oe == ctrl_r[8] &&
    (!ctrl_r[8] || txd_o == ctrl_r[9])) else $error("port pin mismatch");
  a_rx_gate: assert property (!ctrl_r[2] |-> !rx_full_request && !rx_fault_request)
    else $error("receive request without enable");
  a_txe_gate: assert property (!ctrl_r[3] |-> !tx_empty_request)
    else $error("empty request without enable");
  a_txd_gate: assert property (!ctrl_r[4] |-> !tx_done_request)
    else $error("done request without enable");
  a_txe_init: assert property (ctrl_r[3] && !touched_r |-> tx_empty_request)
    else $error("empty request missing after reset");
  a_txd_init: assert property (ctrl_r[4] && !touched_r |-> tx_done_request)
    else $error("done request missing after reset");
  a_tx_idle: assert property (ctrl_r[0] && !touched_r |-> txd_o)
    else $error("transmit pin not idle high");
  a_fault_kept: assert property (wr_ctl && !pwdata[1] && pwdata[2] && rx_fault_request
    |=> rx_fault_request) else $error("fault lost on receiver off");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("unmapped access not refused");
endmodule // silc_chk

bind silc_top silc_chk silc_chk_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe(txd_oe),
  .rx_full_request(rx_full_request), .tx_empty_request(tx_empty_request),
  .tx_done_request(tx_done_request), .rx_fault_request(rx_fault_request));

// file: tb/silc_station.sv
// remote serial station: sends frames on the receive line, captures transmitted ones
module silc_station (
  input wire logic sys_clk,
  input wire logic txd_o,
  input wire logic txd_oe,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  // released transmit pin reads as the pull-up level
  wire pin = txd_oe ? txd_o : 1'b1;
  initial rxd = 1'b1;
  // ====================
  // receive line driving, 16 cycles a bit
  task automatic line(input logic v);
    @(posedge sys_clk);
    rxd <= v;
  endtask
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line(f[i]);
      repeat (15) @(posedge sys_clk);
    end
  endtask
  // capture: find start, then sample mid-bit; returns at mid stop so pin is high
  task automatic get(output logic [7:0] d);
    int k;
    d = 8'hXX;
    k = 0;
    while (pin !== 1'b0 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    if (k < 400) begin
      repeat (7) @(posedge sys_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (16) @(posedge sys_clk);
        if (i < 8) d[i] = pin;
      end
    end
  endtask
endmodule // silc_station

// file: tb/tb.sv
// self-checking bench of the serial line block
`include "silc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rstn, psel, penable, pwrite, e, pready, pslverr, rxd_i, txd_o, txd_oe;
  logic rx_full_request, tx_empty_request, tx_done_request, rx_fault_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] b0, b1;
  int n_fail, n_checks;
  silc_top silc_top_i (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe(txd_oe),
    .rx_full_request(rx_full_request), .tx_empty_request(tx_empty_request),
    .tx_done_request(tx_done_request), .rx_fault_request(rx_fault_request));
  silc_station silc_station_i (.sys_clk(sys_clk), .txd_o(txd_o), .txd_oe(txd_oe), .rxd(rxd_i));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ====================
  // reporting
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic pin(input string n, input logic s, input logic x);
    chk(n, {31'h0, s}, {31'h0, x});
  endtask
  // ====================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
    input string n);
    apb(1'b0, a, 32'h0);
    chk(n, q & m, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // bounded wait for a received word
  task automatic wait_rx();
    int k;
    k = 0;
    while (rx_full_request !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    pin("rx_full_req", rx_full_request, 1'b1);
  endtask
  // ====================
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    n_checks = 0;
    cyc(8);
    rstn <= 1'b1;
    cyc(4);
    rd(`SILC_OFS_STAT, 32'hFFFFFFFF, 32'h00000046, "stat_rst");
    rd(`SILC_OFS_BAUD, 32'hFFFFFFFF, 32'h00000019, "baud_rst");
    rd(12'h020, 32'hFFFFFFFF, 32'h00000000, "unmapped");
    pin("unmapped_err", e, 1'b1);
    wr(`SILC_OFS_BAUD, 32'h00000000);
    wr(`SILC_OFS_CTRL, 32'h00000018);
    cyc(1);
    pin("txe_req", tx_empty_request, 1'b1);
    pin("txd_req", tx_done_request, 1'b1);
    wr(`SILC_OFS_CTRL, 32'h00000300);
    cyc(1);
    pin("mark", txd_o & txd_oe, 1'b1);
    wr(`SILC_OFS_CTRL, 32'h00000309);
    fork
      begin
        silc_station_i.get(b0);
        silc_station_i.get(b1);
      end
      begin
        wr(`SILC_OFS_TXH, 32'h000000A5);
        wr(`SILC_OFS_TXH, 32'h0000003C);
      end
    join
    chk("tx0", {24'h0, b0}, 32'h000000A5);
    chk("tx1", {24'h0, b1}, 32'h0000003C);
    cyc(20);
    rd(`SILC_OFS_STAT, 32'h00000006, 32'h00000006, "tx_end");
    // abort mid-frame while data bits are high, then reenable
    wr(`SILC_OFS_TXH, 32'h0000000F);
    cyc(40);
    wr(`SILC_OFS_CTRL, 32'h00000109);
    wr(`SILC_OFS_CTRL, 32'h00000100);
    cyc(1);
    pin("brk_out", txd_o, 1'b0);
    wr(`SILC_OFS_CTRL, 32'h00000301);
    cyc(40);
    pin("reinit", txd_o, 1'b1);
    wr(`SILC_OFS_CTRL, 32'h00000006);
    silc_station_i.send(8'h3C, 1'b1);
    wait_rx();
    rd(`SILC_OFS_RXH, 32'hFFFFFFFF, 32'h0000003C, "rx0");
    silc_station_i.send(8'h11, 1'b1);
    silc_station_i.send(8'h22, 1'b1);
    cyc(4);
    pin("fault_req", rx_fault_request, 1'b1);
    rd(`SILC_OFS_STAT, 32'h00000039, 32'h00000009, "overrun");
    wr(`SILC_OFS_CTRL, 32'h00000004);
    cyc(1);
    pin("fault_kept", rx_fault_request, 1'b1);
    wr(`SILC_OFS_CTRL, 32'h00000000);
    cyc(1);
    pin("fault_gate", rx_fault_request | rx_full_request, 1'b0);
    rd(`SILC_OFS_RXH, 32'hFFFFFFFF, 32'h00000011, "rx_keep");
    wr(`SILC_OFS_STAT, 32'h00000000);
    // parity: odd check accepts the byte, even check on the same byte must flag it
    wr(`SILC_OFS_CTRL, 32'h00000062);
    silc_station_i.send(8'h03, 1'b1); // last bit acts as parity, idle line as stop
    cyc(16);
    rd(`SILC_OFS_STAT, 32'h00000039, 32'h00000001, "par_odd_ok");
    rd(`SILC_OFS_RXH, 32'hFFFFFFFF, 32'h00000003, "par_data");
    wr(`SILC_OFS_CTRL, 32'h00000026);
    silc_station_i.send(8'h03, 1'b1);
    cyc(16);
    pin("par_fault", rx_fault_request, 1'b1);
    rd(`SILC_OFS_STAT, 32'h00000039, 32'h00000021, "par_err");
    wr(`SILC_OFS_STAT, 32'h00000000);
    // break on the receive line
    wr(`SILC_OFS_CTRL, 32'h00000002);
    silc_station_i.line(1'b0);
    cyc(200);
    rd(`SILC_OFS_STAT, 32'h00000050, 32'h00000010, "brk_fer");
    wr(`SILC_OFS_STAT, 32'h00000000);
    cyc(200);
    rd(`SILC_OFS_STAT, 32'h00000010, 32'h00000010, "brk_again");
    silc_station_i.line(1'b1);
    cyc(200);
    // synchronous mode holds transmit while an error flag stands
    // data loaded before the empty and done enables, so neither request fires early
    wr(`SILC_OFS_TXH, 32'h0000005A);
    wr(`SILC_OFS_CTRL, 32'h00000399);
    cyc(60);
    pin("early_req", tx_empty_request | tx_done_request, 1'b0);
    pin("gated", txd_o, 1'b1);
    rd(`SILC_OFS_STAT, 32'h00000002, 32'h00000000, "gated_txe");
    fork
      silc_station_i.get(b0);
      wr(`SILC_OFS_STAT, 32'h00000000);
    join
    chk("tx_sync", {24'h0, b0}, 32'h0000005A);
    end_sim();
  end
endmodule // tb
